// >>> src/tsxi_pkg.sv
// Purpose: shared constants for the test-port select and external interrupt pin block
// Assumes: classic wishbone with 32-bit data, byte addresses
// Notes: registers hold at most 16 useful bits in the low half of each word
package tsxi_pkg;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] TSXI_ADDR_PULL_DISABLE = 16'h1C18;
	localparam logic [15:0] TSXI_ADDR_IRQ_MASK = 16'h1C20;
	localparam logic [15:0] TSXI_ADDR_IRQ_PENDING = 16'h1C24;
	localparam logic [15:0] TSXI_ADDR_IRQ_CLEAR = 16'h1C28;
	localparam logic [15:0] TSXI_ADDR_IRQ_MODE = 16'h1C2C;
	localparam logic [15:0] TSXI_ADDR_TAP_STATUS = 16'h1C30;
	localparam logic [15:0] TSXI_ADDR_EMU_IRQ = 16'h1C34;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TSXI_BIT_PD_IRQ_A = 0;
	localparam int TSXI_BIT_PD_IRQ_B = 1;
	localparam int TSXI_BIT_PD_EMU_SEL = 2;
	localparam int TSXI_BIT_PD_EMU_AUX = 3;
	localparam int TSXI_BIT_IRQ_A = 0;
	localparam int TSXI_BIT_IRQ_B = 1;
	localparam int TSXI_BIT_IRQ_EMU = 2;
	localparam int TSXI_BIT_MODE_GLOBAL = 0;
	localparam int TSXI_BIT_TAP_SEL = 0;
	localparam int TSXI_BIT_TAP_ARMED = 1;
	localparam int TSXI_BIT_EMU_OE = 0;
	localparam int TSXI_BIT_EMU_OUT = 1;
	// ----------------------------------------------------------------
	// reset values (1 = pull disabled)
	// ----------------------------------------------------------------
	localparam logic [15:0] TSXI_RST_PULL_DISABLE = 16'h0003;
	localparam logic [2:0] TSXI_RST_IRQ_MASK = 3'h0;
	localparam logic [15:0] TSXI_RST_IRQ_MODE = 16'h0000;
	localparam int TSXI_NUM_IRQ = 3;
	// ----------------------------------------------------------------
	// tap selection encoding
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		TSXI_TAP_BSCAN = 1'b0,
		TSXI_TAP_EMUL = 1'b1
	} tsxi_tap_t;
endpackage : tsxi_pkg

// >>> src/tsxi_top.sv
// Purpose: jtag port selection from the emulator select pin, plus the two external
//          interrupt inputs with mask, pending flags and pull control
// Assumes: all pins asynchronous to core_clk; 100 MHz core clock
// Notes: the test clock is only sampled, never used as a clock here
//
// Contract
// - test reset low then high latches emulator select pin level as port choice
// - jtag pins go to boundary scan tap on 0, emulation tap on 1
// - once test reset is high, emulator select pin is a two-way interrupt line
// - emulator select pin pull-up switched by a bit of pull disable register
// - emulator select pin pull-up is enabled after reset
// - each external interrupt maskable by its own mask bit and the mode bit
// - pending flag records each request; software reads it and clears by write
// - both external interrupt pull-ups switched by pull disable register bits
// - both external interrupt pull-ups are disabled after reset
`timescale 1ns/10ps
module tsxi_top
	import tsxi_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// jtag pins from the emulator
	input wire logic jtag_trst_pin,
	input wire logic jtag_tck_pin,
	input wire logic jtag_tms_pin,
	input wire logic jtag_tdi_pin,
	output logic jtag_tdo_pin,
	// boundary scan tap side
	output logic bscan_tck,
	output logic bscan_tms,
	output logic bscan_tdi,
	output logic bscan_trst,
	input wire logic bscan_tdo,
	// emulation tap side
	output logic emul_tck,
	output logic emul_tms,
	output logic emul_tdi,
	output logic emul_trst,
	input wire logic emul_tdo,
	// emulator select pin, two-way
	input wire logic emulator_select_pin_i,
	output logic emulator_select_pin_o,
	output logic emulator_select_pin_oe,
	output logic emulator_select_pullup_en,
	output logic emulator_aux_pullup_en,
	// external interrupt pins, active low
	input wire logic ext_irq_a_n,
	input wire logic ext_irq_b_n,
	output logic ext_irq_a_pullup_en,
	output logic ext_irq_b_pullup_en,
	// interrupt to the cpu
	output logic irq
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] sync_1;
	logic [5:0] sync_2;
	logic trst_prev;
	logic trst_s;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic emu_s;
	logic [1:0] ext_n_s;

	// two flops per pin; only sync_2 is read by logic
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync_1 <= 6'h3F;
			sync_2 <= 6'h3F;
		end else if (clk_en) begin
			sync_1 <= {ext_irq_b_n, ext_irq_a_n, emulator_select_pin_i,
				jtag_tdi_pin, jtag_tms_pin, jtag_tck_pin};
			sync_2 <= sync_1;
		end
	end
	assign tck_s = sync_2[0];
	assign tms_s = sync_2[1];
	assign tdi_s = sync_2[2];
	assign emu_s = sync_2[3];
	assign ext_n_s = sync_2[5:4];

	// test reset has its own pair so it can start low after reset
	logic trst_1;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			trst_1 <= 1'b0;
			trst_s <= 1'b0;
			trst_prev <= 1'b0;
		end else if (clk_en) begin
			trst_1 <= jtag_trst_pin;
			trst_s <= trst_1;
			trst_prev <= trst_s;
		end
	end

	// ----------------------------------------------------------------
	// tap selection
	// ----------------------------------------------------------------
	tsxi_tap_t tap_sel;
	logic armed;
	logic trst_rise;
	assign trst_rise = trst_s && !trst_prev;

	// latch the select pin at the test reset rising edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tap_sel <= TSXI_TAP_BSCAN;
			armed <= 1'b0;
		end else if (clk_en) begin
			if (trst_rise) begin
				tap_sel <= tsxi_tap_t'(emu_s);
			end
			armed <= trst_s;
		end
	end

	// route jtag pins; the unselected tap is held in reset and idle, and with test reset low both taps are held in reset
	always_comb begin
		bscan_tck = (tap_sel == TSXI_TAP_BSCAN) && tck_s;
		bscan_tms = (tap_sel == TSXI_TAP_BSCAN) && tms_s;
		bscan_tdi = (tap_sel == TSXI_TAP_BSCAN) && tdi_s;
		bscan_trst = (tap_sel == TSXI_TAP_BSCAN) && trst_s;
		emul_tck = (tap_sel == TSXI_TAP_EMUL) && tck_s;
		emul_tms = (tap_sel == TSXI_TAP_EMUL) && tms_s;
		emul_tdi = (tap_sel == TSXI_TAP_EMUL) && tdi_s;
		emul_trst = (tap_sel == TSXI_TAP_EMUL) && trst_s;
	end

	// tdo comes from a flop to keep the pin glitch free
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			jtag_tdo_pin <= 1'b0;
		end else if (clk_en) begin
			jtag_tdo_pin <= (tap_sel == TSXI_TAP_EMUL) ? emul_tdo : bscan_tdo;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] pull_disable_ctrl_2;
	logic [2:0] irq_mask;
	logic [2:0] irq_pending;
	logic [15:0] irq_mode;
	logic [1:0] emu_ctrl;
	logic wr_req;
	logic rd_req;
	logic hit;
	logic [2:0] clr_w;
	logic [15:0] wmask;

	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !wb_err_o;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb begin
		case (wb_adr_i)
			TSXI_ADDR_PULL_DISABLE: hit = 1'b1;
			TSXI_ADDR_IRQ_MASK: hit = 1'b1;
			TSXI_ADDR_IRQ_PENDING: hit = 1'b1;
			TSXI_ADDR_IRQ_CLEAR: hit = 1'b1;
			TSXI_ADDR_IRQ_MODE: hit = 1'b1;
			TSXI_ADDR_TAP_STATUS: hit = 1'b1;
			TSXI_ADDR_EMU_IRQ: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// pull control; a set bit disables the pull
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pull_disable_ctrl_2 <= TSXI_RST_PULL_DISABLE;
		end else if (clk_en && wr_req && wb_adr_i == TSXI_ADDR_PULL_DISABLE) begin
			pull_disable_ctrl_2 <= (pull_disable_ctrl_2 & ~wmask) | (wb_dat_i[15:0] & wmask);
		end
	end
	assign emulator_select_pullup_en = !pull_disable_ctrl_2[TSXI_BIT_PD_EMU_SEL];
	assign emulator_aux_pullup_en = !pull_disable_ctrl_2[TSXI_BIT_PD_EMU_AUX];
	assign ext_irq_a_pullup_en = !pull_disable_ctrl_2[TSXI_BIT_PD_IRQ_A];
	assign ext_irq_b_pullup_en = !pull_disable_ctrl_2[TSXI_BIT_PD_IRQ_B];

	// mask, mode and emulator line control
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_mask <= TSXI_RST_IRQ_MASK;
			irq_mode <= TSXI_RST_IRQ_MODE;
			emu_ctrl <= 2'h0;
		end else if (clk_en && wr_req && wb_sel_i[0]) begin
			if (wb_adr_i == TSXI_ADDR_IRQ_MASK) begin
				irq_mask <= wb_dat_i[2:0];
			end
			if (wb_adr_i == TSXI_ADDR_IRQ_MODE) begin
				irq_mode <= wb_dat_i[15:0];
			end
			if (wb_adr_i == TSXI_ADDR_EMU_IRQ) begin
				emu_ctrl <= wb_dat_i[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// emulator interrupt line
	// ----------------------------------------------------------------
	// the pin is only driven once test reset is high, so the latched level is never fought
	assign emulator_select_pin_oe = armed && trst_s && emu_ctrl[TSXI_BIT_EMU_OE];
	assign emulator_select_pin_o = emu_ctrl[TSXI_BIT_EMU_OUT];

	// ----------------------------------------------------------------
	// event detection and pending flags
	// ----------------------------------------------------------------
	logic [2:0] req_lvl;
	logic [2:0] req_prev;
	logic [2:0] req_edge;
	assign req_lvl = {armed && !emulator_select_pin_oe && !emu_s, ~ext_n_s};
	assign req_edge = req_lvl & ~req_prev;
	assign clr_w = (clk_en && wr_req && wb_sel_i[0] && wb_adr_i == TSXI_ADDR_IRQ_CLEAR)
		? wb_dat_i[2:0] : 3'h0;

	// falling pin edge marks a request; set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			req_prev <= 3'h0;
			irq_pending <= 3'h0;
		end else if (clk_en) begin
			req_prev <= req_lvl;
			irq_pending <= (irq_pending & ~clr_w) | req_edge;
		end
	end

	// cpu interrupt needs the per-line mask and the global mode bit
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= irq_mode[TSXI_BIT_MODE_GLOBAL] && |(irq_pending & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// bus answer: one cycle after the request, unmapped gives err
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			wb_ack_o <= (wr_req || rd_req) && hit;
			wb_err_o <= (wr_req || rd_req) && !hit;
			wb_dat_o <= 32'h0000_0000;
			if (rd_req) begin
				case (wb_adr_i)
					TSXI_ADDR_PULL_DISABLE: wb_dat_o <= {16'h0000, pull_disable_ctrl_2};
					TSXI_ADDR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
					TSXI_ADDR_IRQ_PENDING: wb_dat_o <= {29'h0, irq_pending};
					TSXI_ADDR_IRQ_MODE: wb_dat_o <= {16'h0000, irq_mode};
					TSXI_ADDR_TAP_STATUS: wb_dat_o <= {30'h0, armed, tap_sel};
					TSXI_ADDR_EMU_IRQ: wb_dat_o <= {30'h0, emu_ctrl};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_trst_rise;
		!trst_prev && trst_s;
	endsequence

	a_tap_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
		(s_trst_rise and clk_en) |=> tap_sel == $past(emu_s))
		else $error("tap selection did not latch the select pin");
	a_tap_route: assert property (@(posedge core_clk) disable iff (!rst_n)
		tap_sel == TSXI_TAP_EMUL |-> !bscan_tck && emul_tck == tck_s)
		else $error("jtag clock routed to the wrong tap");
	a_emu_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		emulator_select_pin_oe |-> trst_s && armed)
		else $error("select pin driven while test reset low");
	a_emu_pullup: assert property (@(posedge core_clk) disable iff (!rst_n)
		emulator_select_pullup_en != pull_disable_ctrl_2[TSXI_BIT_PD_EMU_SEL])
		else $error("select pin pull does not follow control");
	a_pull_reset: assert property (@(posedge core_clk)
		$rose(rst_n) |-> emulator_select_pullup_en && !ext_irq_a_pullup_en && !ext_irq_b_pullup_en)
		else $error("pull state wrong after reset");
	a_irq_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !irq_mode[TSXI_BIT_MODE_GLOBAL] |=> !irq)
		else $error("interrupt raised with mode bit clear");
	a_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && req_edge[TSXI_BIT_IRQ_A] |=> irq_pending[TSXI_BIT_IRQ_A])
		else $error("request lost on line a");
	a_sync_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en ##1 clk_en ##1 clk_en |-> ext_n_s[0] == $past(ext_irq_a_n, 2))
		else $error("interrupt pin not passed through two flops");
	a_pull_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_irq_b_pullup_en == !pull_disable_ctrl_2[TSXI_BIT_PD_IRQ_B])
		else $error("line b pull does not follow control");

	// tap resets are active low: the chosen tap runs only while test reset is high
	a_trst_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!trst_s |-> !bscan_trst && !emul_trst)
		else $error("tap left running with test reset low");
	a_trst_run: assert property (@(posedge core_clk) disable iff (!rst_n)
		trst_s |-> bscan_trst == (tap_sel == TSXI_TAP_BSCAN) && emul_trst == !bscan_trst)
		else $error("wrong tap released from reset");
	a_tap_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !trst_rise |=> $stable(tap_sel))
		else $error("tap selection changed without a test reset rise");

	// flags: a fresh request always lands, a clear alone removes it
	a_flag_set_b: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && req_edge[TSXI_BIT_IRQ_B] |=> irq_pending[TSXI_BIT_IRQ_B])
		else $error("request lost on line b");
	a_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		clr_w[TSXI_BIT_IRQ_A] && !req_edge[TSXI_BIT_IRQ_A] |=> !irq_pending[TSXI_BIT_IRQ_A])
		else $error("flag on line a not cleared");

	// emulator line requests, interrupt raise and the line b synchroniser lane
	a_emu_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && req_edge[TSXI_BIT_IRQ_EMU] |=> irq_pending[TSXI_BIT_IRQ_EMU])
		else $error("emulator line request lost");
	a_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && irq_mode[TSXI_BIT_MODE_GLOBAL] && |(irq_pending & irq_mask) |=> irq)
		else $error("enabled pending request gave no interrupt");
	a_sync_b: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en ##1 clk_en ##1 clk_en |-> ext_n_s[1] == $past(ext_irq_b_n, 2))
		else $error("line b pin not passed through two flops");

endmodule : tsxi_top

// >>> dv/tsxi_far_end.sv
// Purpose: far-end model, jtag emulator and external interrupt sources
// Assumes: the bench calls one task at a time, right after a rising edge
// Notes: tck runs only while shifting and stands low between frames
`timescale 1ns/10ps
module tsxi_far_end (
	// clock
	input wire logic core_clk,
	// pins toward the block
	output logic trst,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic sel_oe,
	output logic sel_v,
	output logic irq_a_n,
	output logic irq_b_n
);
	initial begin
		{trst, tck, tms, tdi, sel_oe, sel_v} = 6'h00;
		{irq_a_n, irq_b_n} = 2'h3;
	end
	// test reset pulse with the select level held across the rising edge
	task automatic tap_reset(input logic lvl);
		@(posedge core_clk);
		trst <= 1'b0;
		sel_oe <= 1'b1;
		sel_v <= lvl;
		repeat (4) @(posedge core_clk);
		trst <= 1'b1;
		// held past the arming cycle, so a low level also requests
		repeat (10) @(posedge core_clk);
		sel_oe <= 1'b0;
	endtask : tap_reset
	// one 80 ns tck period carrying new tms and tdi
	task automatic shift(input logic m, input logic d);
		@(posedge core_clk);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge core_clk);
		tck <= 1'b1;
		repeat (4) @(posedge core_clk);
		tck <= 1'b0;
	endtask : shift
	// low long enough for the two-flop synchroniser to see it
	task automatic pulse(input logic b);
		@(posedge core_clk);
		if (b) irq_b_n <= 1'b0;
		else irq_a_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		{irq_a_n, irq_b_n} <= 2'h3;
	endtask : pulse
endmodule : tsxi_far_end

// >>> dv/tsxi_top_bench.sv
// Purpose: self-checking bench for the tap select and external interrupt block
// Assumes: ack or err answers one cycle after a request is taken
// Notes: read data expectations go through a queue checked at ack
`timescale 1ns/10ps
module tsxi_top_bench;
	import tsxi_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, wb_err_o, jtag_tdo_pin, irq, er, tog = 1'b0, f_oe, f_v;
	logic jtag_trst_pin, jtag_tck_pin, jtag_tms_pin, jtag_tdi_pin, ext_irq_a_n, ext_irq_b_n;
	logic bscan_tck, bscan_tms, bscan_tdi, bscan_trst, emul_tck, emul_tms, emul_tdi, emul_trst;
	logic bscan_tdo = 1'b0, emul_tdo = 1'b0, emulator_select_pin_i;
	logic emulator_select_pin_o, emulator_select_pin_oe, emulator_select_pullup_en;
	logic emulator_aux_pullup_en, ext_irq_a_pullup_en, ext_irq_b_pullup_en;
	logic [31:0] exp_q[$];
	logic [31:0] r;
	int seed = 32'haaec3e1b;
	int error_cnt = 0, compares = 0, cyc_cnt = 0;
	int etck_n = 0, btck_n = 0, etck_0 = 0, btck_0 = 0;
	always #5 core_clk = ~core_clk;
	// undriven line without pull flips each cycle so a stale level never passes
	always @(posedge core_clk) tog <= ~tog;
	// routed test clock pulses, counted per tap
	always @(posedge emul_tck) etck_n++;
	always @(posedge bscan_tck) btck_n++;
	assign emulator_select_pin_i = emulator_select_pin_oe ? emulator_select_pin_o :
		f_oe ? f_v : emulator_select_pullup_en ? 1'b1 : tog;
	tsxi_top dut_u (.core_clk, .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .jtag_trst_pin, .jtag_tck_pin,
		.jtag_tms_pin, .jtag_tdi_pin, .jtag_tdo_pin, .bscan_tck, .bscan_tms, .bscan_tdi,
		.bscan_trst, .bscan_tdo, .emul_tck, .emul_tms, .emul_tdi, .emul_trst, .emul_tdo,
		.emulator_select_pin_i, .emulator_select_pin_o, .emulator_select_pin_oe,
		.emulator_select_pullup_en, .emulator_aux_pullup_en, .ext_irq_a_n, .ext_irq_b_n,
		.ext_irq_a_pullup_en, .ext_irq_b_pullup_en, .irq);
	tsxi_far_end far_u (.core_clk, .trst(jtag_trst_pin), .tck(jtag_tck_pin),
		.tms(jtag_tms_pin), .tdi(jtag_tdi_pin), .sel_oe(f_oe), .sel_v(f_v),
		.irq_a_n(ext_irq_a_n), .irq_b_n(ext_irq_b_n));
	task automatic conclude;
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// classic single cycle; a read notes its expected data for the monitor
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic e);
		int n;
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, w, a};
		wb_dat_i <= w ? d : 32'h0000_0000;
		if (!w && a != 16'h1C40) exp_q.push_back(d);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		e = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (n >= 20) error_cnt++;
	endtask : wb
	// monitor: oldest note against read data at each read ack
	always @(posedge core_clk) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			chk("read data", exp_q.size() ? exp_q.pop_front() : 32'hX, wb_dat_o);
		end
	end
	// hang guard, far above the fewer than 200 cycles of the sequence
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		r = $random(seed);
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		chk("pulls", 32'hC, {emulator_aux_pullup_en, emulator_select_pullup_en,
			ext_irq_b_pullup_en, ext_irq_a_pullup_en});
		wb(1'b0, TSXI_ADDR_PULL_DISABLE, 32'h3, er);
		wb(1'b1, TSXI_ADDR_PULL_DISABLE, {28'h0, r[3:0]}, er);
		chk("pulls", {28'h0, ~r[3:0]}, {emulator_aux_pullup_en,
			emulator_select_pullup_en, ext_irq_b_pullup_en, ext_irq_a_pullup_en});
		wb(1'b1, TSXI_ADDR_PULL_DISABLE, 32'h3, er);
		wb(1'b0, 16'h1C40, 32'h0, er);
		chk("unmapped err", 32'h1, {31'h0, er});
		emul_tdo <= r[6];
		far_u.tap_reset(1'b1);
		wb(1'b0, TSXI_ADDR_TAP_STATUS, 32'h3, er);
		etck_0 = etck_n;
		btck_0 = btck_n;
		far_u.shift(r[4], r[5]);
		chk("emul route", {r[4], r[5], 1'b0, r[6]},
			{emul_tms, emul_tdi, bscan_tms, jtag_tdo_pin});
		chk("emul trst", 32'h2, {30'h0, emul_trst, bscan_trst});
		chk("emul tck", etck_0 + 1, etck_n);
		chk("bscan tck idle", btck_0, btck_n);
		wb(1'b1, TSXI_ADDR_IRQ_MASK, 32'h1, er);
		far_u.pulse(1'b0);
		far_u.pulse(1'b1);
		repeat (4) @(posedge core_clk);
		chk("irq mode off", 32'h0, {31'h0, irq});
		wb(1'b1, TSXI_ADDR_IRQ_MODE, 32'h1, er);
		repeat (3) @(posedge core_clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wb(1'b0, TSXI_ADDR_IRQ_PENDING, 32'h3, er);
		wb(1'b1, TSXI_ADDR_IRQ_CLEAR, 32'h1, er);
		repeat (3) @(posedge core_clk);
		chk("irq b masked", 32'h0, {31'h0, irq});
		wb(1'b0, TSXI_ADDR_IRQ_PENDING, 32'h2, er);
		// a pulse while the block is frozen must leave no trace
		clk_en <= 1'b0;
		far_u.pulse(1'b0);
		clk_en <= 1'b1;
		wb(1'b0, TSXI_ADDR_IRQ_PENDING, 32'h2, er);
		wb(1'b1, TSXI_ADDR_IRQ_CLEAR, 32'h3, er);
		bscan_tdo <= r[9];
		far_u.tap_reset(1'b0);
		wb(1'b0, TSXI_ADDR_TAP_STATUS, 32'h2, er);
		etck_0 = etck_n;
		btck_0 = btck_n;
		far_u.shift(r[7], r[8]);
		chk("bscan route", {r[7], r[8], 1'b0, r[9]},
			{bscan_tms, bscan_tdi, emul_tms, jtag_tdo_pin});
		chk("bscan trst", 32'h1, {30'h0, emul_trst, bscan_trst});
		chk("bscan tck", btck_0 + 1, btck_n);
		chk("emul tck idle", etck_0, etck_n);
		wb(1'b0, TSXI_ADDR_IRQ_PENDING, 32'h4, er);
		wb(1'b1, TSXI_ADDR_EMU_IRQ, 32'h3, er);
		wb(1'b1, TSXI_ADDR_IRQ_MASK, 32'h4, er);
		repeat (3) @(posedge core_clk);
		chk("emu line", 32'h7, {29'h0, emulator_select_pin_oe, emulator_select_pin_i, irq});
		conclude();
	end
endmodule : tsxi_top_bench
